// >>> hw/refclk_divider.sv
// Reference clock output unit with APB control register
`timescale 1ns/1ps

// Operation
// R1 - The divider counts only the system clock, whatever oscillator provides it.
// R2 - In Sleep the unit stops because the system clock stops, whatever its source.
// R3 - In Sleep the outputs keep their level and change again only after waking; undivided mode still passes REF_CLK to the pin.
// R4 - The divided clock reaches the pin only with both the unit enable and pin output enable set.
// R5 - Routing the reference clock to the pin also needs the configuration override bit at 1.
// R6 - With the configuration override bit at 0 the pin carries the oscillator divided by four.
// R7 - Undivided, the output follows the source clock duty except 0 percent, which holds it low.
// R8 - At divide by two, 25 and 75 percent duty may be built from source edges and depend on them; here divide by two gives 50 percent for both.
// R9 - Any reset disables the unit and returns the control register to its defaults.
// R10 - The slew control bit enables slew limiting on the pin when set and removes it when clear.
// R11 - A two-bit duty field picks the duty and a three-bit divider field picks one of eight ratios.
// R12 - Divider codes 000 to 111 divide by 1, 2, 4, 8, 16, 32, 64 and 128.
// R13 - Duty codes 00, 01, 10 and 11 give 0, 25, 50 and 75 percent.
module refclk_divider
  import refclk_pkg::*;
#(
  parameter int ADDR_W = BUS_AW
) (
  // Clock, reset and Sleep freeze
  input  wire logic              REF_CLK,
  input  wire logic              RESET,
  input  wire logic              CLK_EN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic                   PREADY,
  output logic [31:0]            PRDATA,
  output logic                   PSLVERR,
  // Configuration word
  input  wire logic              SYSCLK_OUT_OVERRIDE_CFG,
  // Output pin
  output logic                   REFCLK_OUT_PIN_O,
  output logic                   REFCLK_OUT_PIN_OE,
  output logic                   REFCLK_SLEW_LIMIT
);

  logic [CTL_W-1:0]      ctl;
  logic                  pready_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;
  logic [FOSC_DIV_W-1:0] fosc_div;
  logic                  pin_q;
  logic                  pin_oe_q;
  logic                  pass_q;

  refclk_if wave_bus ();

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire       refclk_unit_enable       = ctl[EN_BIT];
  wire       refclk_pin_output_enable = ctl[OE_BIT];
  wire       refclk_slew_limit        = ctl[SLR_BIT];
  wire [1:0] refclk_duty_select       = ctl[DUTY_LSB +: 2];  // [R11]
  wire [2:0] refclk_divider_select    = ctl[DIV_LSB +: 3];   // [R11]

  assign wave_bus.enable  = refclk_unit_enable;
  assign wave_bus.divider = refclk_divider_select;
  assign wave_bus.duty    = refclk_duty_select;

  refclk_wave u_wave (
    .clk (REF_CLK),
    .rst (RESET),
    .ce  (CLK_EN),
    .bus (wave_bus)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access   = PSEL & PENABLE;
  wire complete = access & pready_q;
  wire answer   = access & ~pready_q;
  wire hit_ctl  = PADDR == ADDR_W'(OFS_CTL);
  wire hit_stat = PADDR == ADDR_W'(OFS_STAT);
  wire wr_ctl   = complete & PWRITE & hit_ctl & PSTRB[0];

  wire [31:0] stat_word = {28'h000_0000, pass_q, ~SYSCLK_OUT_OVERRIDE_CFG, pin_oe_q, pin_q};
  wire [31:0] rd_word   = hit_ctl  ? {24'h00_0000, ctl} :
                          hit_stat ? stat_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  wire routed      = SYSCLK_OUT_OVERRIDE_CFG & refclk_unit_enable & refclk_pin_output_enable; // [R4] [R5]
  wire next_pin_oe = ~SYSCLK_OUT_OVERRIDE_CFG | routed;                                       // [R6]
  wire next_pin_o  = ~SYSCLK_OUT_OVERRIDE_CFG ? fosc_div[FOSC_DIV_W-1] :                      // [R6]
                     routed & wave_bus.wave;                                                   // [R4]
  wire next_pass   = routed & refclk_divider_select == DIV_BY_1 &
                     refclk_duty_select != DUTY_OFF;                                           // [R7]

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Low clock enable stands for Sleep: every register here holds its value
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctl       <= CTL_RESET;                                                 // [R9]
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (CLK_EN) begin                                                // [R2]
      pready_q  <= answer;
      prdata_q  <= answer ? rd_word : prdata_q;
      pslverr_q <= answer & ~(hit_ctl | hit_stat);
      if (wr_ctl)
        ctl <= PWDATA[CTL_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      fosc_div <= '0;
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
      pass_q   <= 1'b0;
    end else if (CLK_EN) begin                                                // [R3]
      fosc_div <= fosc_div + 1'b1;                                            // [R1]
      pin_q    <= next_pin_o;
      pin_oe_q <= next_pin_oe;
      pass_q   <= next_pass;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Undivided mode hands the source clock itself to the pin, so its duty is the source's
  assign REFCLK_OUT_PIN_O  = pass_q ? REF_CLK : pin_q;                         // [R7]
  assign REFCLK_OUT_PIN_OE = pin_oe_q;
  assign REFCLK_SLEW_LIMIT = refclk_slew_limit;                                // [R10]
  assign PREADY            = pready_q;
  assign PRDATA            = prdata_q;
  assign PSLVERR           = pslverr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  AST_RESET_DEFAULTS: assert property (@(posedge REF_CLK) disable iff (1'b0) RESET |=> ctl == CTL_RESET && !pass_q) // [R9]
    else $error("Reset did not restore control defaults");
  AST_PIN_BLOCKED: assert property (CLK_EN && SYSCLK_OUT_OVERRIDE_CFG &&
    !(refclk_unit_enable && refclk_pin_output_enable) |=> !REFCLK_OUT_PIN_OE && !pin_q) // [R4]
    else $error("Pin driven while unit or output enable is clear");
  AST_PIN_ROUTED: assert property (CLK_EN && SYSCLK_OUT_OVERRIDE_CFG && refclk_unit_enable &&
    refclk_pin_output_enable |=> REFCLK_OUT_PIN_OE) // [R5]
    else $error("Reference clock not routed with all enables set");
  AST_FOSC4: assert property ((CLK_EN && !SYSCLK_OUT_OVERRIDE_CFG)[*6]
    |-> REFCLK_OUT_PIN_OE && pin_q != $past(pin_q, 2) && pin_q == $past(pin_q, 4)) // [R6]
    else $error("Override does not give the oscillator divided by four");
  AST_SLEEP_HOLD: assert property (!CLK_EN && !pass_q |=> $stable(REFCLK_OUT_PIN_O) &&
    $stable(REFCLK_OUT_PIN_OE) && $stable(REFCLK_SLEW_LIMIT) && $stable(PREADY)) // [R3]
    else $error("Outputs changed during Sleep");
  AST_PASS_THROUGH: assert property (CLK_EN && next_pass |=> pass_q ##0 REFCLK_OUT_PIN_O == REF_CLK) // [R7]
    else $error("Undivided mode does not pass the source clock");
  AST_SLEW_WRITE: assert property (CLK_EN && wr_ctl |=> REFCLK_SLEW_LIMIT == $past(PWDATA[SLR_BIT])) // [R10]
    else $error("Slew limit does not follow the written bit");
  AST_APB_ANSWER: assert property (CLK_EN && answer |=> PREADY ##0 PSLVERR == !$past(hit_ctl || hit_stat))
    else $error("APB answer missing or wrong error flag");

  COV_ROUTED_WRITE: cover property (wr_ctl ##1 routed ##[1:8] $rose(pin_q));
  COV_OVERRIDE:     cover property (!SYSCLK_OUT_OVERRIDE_CFG && $rose(pin_q));
  COV_SLEEP:        cover property (routed && !CLK_EN [*3] ##1 CLK_EN);
endmodule : refclk_divider

// >>> hw/refclk_wave.sv
// Power-of-two divider and duty shaper for the reference clock
`timescale 1ns/1ps
module refclk_wave
  import refclk_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control in, waveform out
  refclk_if.gen    bus
);

  logic [CNT_W-1:0] cnt;
  logic             wave_q;

  // ----------------------------------------------------------------
  // Level for a counter phase
  // ----------------------------------------------------------------
  // Only rising edges exist here, so divide-by-2 cannot make 25 or 75 percent
  function automatic logic wave_level(input logic [CNT_W-1:0] c, input logic [2:0] div,
                                      input logic [1:0] duty);
    logic [1:0] quarter;
    quarter = 2'h0;
    if (duty == DUTY_OFF)
      return 1'b0;                                     // [R7]
    if (div == DIV_BY_1)
      return 1'b1;
    if (div == DIV_BY_2)
      return ~c[0];                                    // [R8]
    quarter = 2'(c >> (div - 3'h2));
    return quarter < duty;                             // [R13]
  endfunction : wave_level

  wire next_wave = bus.enable & wave_level(cnt, bus.divider, bus.duty);

  // ----------------------------------------------------------------
  // Counter on the system clock only
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt    <= '0;
      wave_q <= 1'b0;
    end else if (ce) begin
      cnt    <= bus.enable ? cnt + 1'b1 : '0;          // [R1] [R12]
      wave_q <= next_wave;
    end
  end

  assign bus.wave = wave_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_DUTY_ZERO_LOW: assert property (ce && bus.duty == DUTY_OFF |=> !wave_q) // [R7]
    else $error("Duty zero did not hold the wave low");
  AST_DIV4_HALF: assert property ((ce && bus.enable && bus.divider == 3'h2 && bus.duty == 2'h2)[*6]
    |-> wave_q == $past(wave_q, 4) && wave_q != $past(wave_q, 2)) // [R12]
    else $error("Divide by 4 at half duty has wrong period");
  AST_DIV8_QUARTER: assert property ((ce && bus.enable && bus.divider == 3'h3 && bus.duty == 2'h1)[*3]
    ##0 $rose(wave_q) ##1 (ce && bus.enable && bus.divider == 3'h3 && bus.duty == 2'h1)
    |-> wave_q ##1 !wave_q) // [R13]
    else $error("Quarter duty at divide by 8 is not two cycles high");
  COV_DIV128: cover property (bus.enable && bus.divider == 3'h7 && $rose(wave_q));
endmodule : refclk_wave

// >>> inc/refclk_if.sv
// Control and waveform signals between the register side and the generator
`timescale 1ns/1ps
interface refclk_if;
  logic       enable;
  logic [2:0] divider;
  logic [1:0] duty;
  logic       wave;

  modport ctl (output enable, output divider, output duty, input wave);
  modport gen (input enable, input divider, input duty, output wave);
endinterface : refclk_if

// >>> inc/refclk_pkg.sv
// Constants shared by the reference clock divider and its waveform generator
package refclk_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         BUS_AW     = 8;
  localparam logic [7:0] OFS_CTL    = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam int         CTL_W      = 8;
  localparam logic [7:0] CTL_RESET  = 8'h30;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int         EN_BIT     = 7;
  localparam int         OE_BIT     = 6;
  localparam int         SLR_BIT    = 5;
  localparam int         DUTY_LSB   = 3;
  localparam int         DIV_LSB    = 0;
  localparam logic [1:0] DUTY_OFF   = 2'h0;
  localparam logic [2:0] DIV_BY_1   = 3'h0;
  localparam logic [2:0] DIV_BY_2   = 3'h1;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int         STAT_PIN   = 0;
  localparam int         STAT_OE    = 1;
  localparam int         STAT_OVR   = 2;
  localparam int         STAT_PASS  = 3;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  localparam int         CNT_W      = 7;
  localparam int         FOSC_DIV_W = 2;

endpackage : refclk_pkg

// >>> sim/refclk_sink.sv
// Model of an external device that samples the reference clock pin on the system clock
`timescale 1ns/1ps
module refclk_sink (
  // Clock and pin
  input  wire logic clk,
  input  wire logic pin,
  input  wire logic oe,
  // Measured waveform, in system clock cycles
  output int        period,
  output int        high_time
);
  int   cnt   = 0;
  int   hcnt  = 0;
  logic last  = 1'b0;

  // ----------------------------------------------------------------
  // Edge timing
  // ----------------------------------------------------------------
  // An undriven pin is read as low, so a released pin never counts as a rise
  always @(posedge clk) begin
    last <= oe & pin;
    if (oe && pin && !last) begin
      period    <= cnt;
      high_time <= hcnt;
      cnt       <= 1;
      hcnt      <= 1;
    end else begin
      cnt  <= cnt + 1;
      hcnt <= hcnt + int'(oe & pin);
    end
  end
endmodule : refclk_sink

// >>> sim/testbench.sv
// Self-checking bench for the reference clock divider
`timescale 1ns/1ps
module testbench;
  import refclk_pkg::*;
  typedef struct { logic [7:0] ctl; logic ovr; logic oe; int per; int hi; } row_s;
  logic clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, ovr, pin_o, pin_oe, slew, er, s;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          per, hi, mismatches, checks_done, changes;
  row_s rows [8] = '{'{8'hF2,1,1,4,2}, '{8'hCB,1,1,8,2}, '{8'hDB,1,1,8,6}, '{8'hD7,1,1,128,64},
                     '{8'hC9,1,1,2,1}, '{8'h92,1,0,0,0}, '{8'h52,1,0,0,0}, '{8'h00,0,1,4,2}};

  refclk_divider dut (.REF_CLK(clk), .RESET(rst), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .SYSCLK_OUT_OVERRIDE_CFG(ovr), .REFCLK_OUT_PIN_O(pin_o),
    .REFCLK_OUT_PIN_OE(pin_oe), .REFCLK_SLEW_LIMIT(slew));
  refclk_sink sink (.clk(clk), .pin(pin_o), .oe(pin_oe), .period(per), .high_time(hi));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One APB transfer; the answer is taken at the edge where PREADY is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  initial begin
    rst = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; ovr = 1'b1;
    paddr = 8'h00; pwdata = 32'h0000_0000; pstrb = 4'h0; mismatches = 0; checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe_reset", 0, pin_oe);
    chk("slew_reset", 1, slew);
    apb(0, OFS_CTL, 0);
    chk("ctl_reset", 32'h0000_0030, rd);
    $display("reset test done");
    foreach (rows[k]) begin
      ovr <= rows[k].ovr;
      apb(1, OFS_CTL, {24'h00_0000, rows[k].ctl});
      repeat (300) @(posedge clk);
      @(negedge clk);
      chk("pin_oe", rows[k].oe, pin_oe);
      chk("slew", rows[k].ctl[SLR_BIT], slew);
      if (rows[k].oe) begin
        chk("period", rows[k].per, per);
        chk("high", rows[k].hi, hi);
      end else chk("pin", 0, pin_o);
    end
    $display("row tests done");
    ovr <= 1'b1;
    apb(0, 8'h08, 0);
    chk("slverr", 1, er);
    chk("unmapped_data", 0, rd);
    apb(1, OFS_CTL, 32'h0000_00D0);
    repeat (4) @(posedge clk);
    #25 chk("pass_high", 1, pin_o);
    #50 chk("pass_low", 0, pin_o);
    apb(1, OFS_CTL, 32'h0000_00C0);
    repeat (4) @(posedge clk);
    #25 chk("duty0_low", 0, pin_o);
    apb(0, OFS_STAT, 0);
    chk("stat", 32'h0000_0002, rd);
    $display("undivided test done");
    apb(1, OFS_CTL, 32'h0000_00D2);
    repeat (20) @(posedge clk);
    clk_en <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    s = pin_o;
    changes = 0;
    repeat (40) @(negedge clk) if (pin_o !== s) changes++;
    chk("sleep_hold", 0, changes);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (20) @(posedge clk);
    chk("wake_period", 4, per);
    $display("sleep test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe_rereset", 0, pin_oe);
    apb(0, OFS_CTL, 0);
    chk("ctl_rereset", 32'h0000_0030, rd);
    $display("second reset test done");
    close_out();
  end
endmodule : testbench
